/* File: inc/rxbuf_defs.svh */
// Register offsets, field positions and reset values of the receive buffer control block.
`ifndef RXBUF_DEFS_SVH
`define RXBUF_DEFS_SVH
`define OFS_COMPLETION_HANDLING  12'h0108
`define OFS_COMPLETION_ADVERT    12'h010c
`define OFS_INTEGRITY_CONTROL    12'h0110
`define OFS_INTEGRITY_FLAGS      12'h0114
`define OFS_CREDIT_VIEW_SELECT   12'h0120
`define OFS_POSTED_CREDIT_VIEW   12'h0124
`define OFS_NONPOSTED_CREDIT_VIEW 12'h0128
`define OFS_COMPLETION_CREDIT_VIEW 12'h012c
`define BIT_PRIORITY             0
`define BIT_RELAXED_OVERRIDE     1
`define BIT_PARITY_REPORT_OFF    18
`define BIT_PREFIX_TRIGGER       17
`define BIT_PARITY_TRIGGER       16
`define BIT_DOUBLE_REPORT_OFF    12
`define BIT_DOUBLE_HANDLING_OFF  11
`define BIT_DOUBLE_TRIGGER       8
`define BIT_SINGLE_REPORT_OFF    4
`define BIT_SINGLE_CORRECT_OFF   3
`define BIT_SINGLE_TRIGGER       0
`define FLAG_PREFIX              3
`define FLAG_PARITY              2
`define FLAG_DOUBLE              1
`define FLAG_SINGLE              0
`define CONTROL_MASK             32'h0007_1919
`define RESET_ZERO               32'h0000_0000
`define MAX_ADV_HDR              16'h007f
`define MAX_ADV_DATA             16'h07ff
`define INFINITE_CREDIT          16'h0000
`define ARB_STARVE_LIMIT         4'h8
`endif

/* File: inc/rxbuf_pkg.sv */
// Types shared by the receive buffer control block.
package rxbuf_pkg;
  typedef enum logic [1:0] {
    ADV_BY_PORT  = 2'h0,
    ADV_ACTUAL   = 2'h1,
    ADV_INFINITE = 2'h2,
    ADV_RSVD     = 2'h3
  } advert_choice_type;
  typedef enum logic [1:0] {
    VIEW_INITIAL     = 2'h0,
    VIEW_CURRENT     = 2'h1,
    VIEW_IMPLEMENTED = 2'h2,
    VIEW_RSVD        = 2'h3
  } credit_view_choice_type;
  typedef enum logic [1:0] {
    ARB_POSTED    = 2'h0,
    ARB_NONPOSTED = 2'h1,
    ARB_COMPL     = 2'h3
  } arb_state_type;
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] hdr;
  } credit_pair_type;
  typedef struct packed {
    credit_pair_type p;
    credit_pair_type n;
    credit_pair_type c;
  } credit_set_type;
endpackage : rxbuf_pkg

/* File: core/rx_buffer_control.sv */
// Receive buffer control: arbitration, credit views, parity/ECC control and status.
//
// Behaviour
// - Override makes every completion relaxed-ordered.
// - Priority off: round-robin among P, NP, C.
// - Priority on: completions first, anti-starvation.
// - Advert choice: port type, actual, infinite.
// - Prefix parity trigger edge injects once.
// - Parity trigger edge injects once.
// - Double-bit trigger edge injects on read.
// - Single-bit trigger edge injects on read.
// - Parity report-off suppresses parity reports.
// - Double-bit report-off suppresses its reports.
// - Double-bit handling-off skips its handling.
// - Single-bit report-off suppresses its reports.
// - Correction off: single-bit acts as double.
// - Four sticky error flags, write one clears.
// - View choice: initial, current, implemented.
// - Implemented view may exceed advertised maximum.
// - Posted view: data high, header low.
// - Non-posted view: data high, header low.
// - Completion view: data high, header low.
`include "rxbuf_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module rx_buffer_control #(
  parameter int ADDR_W = 12
) (
  input  wire logic                    clk,                 // Core clock, 25 MHz.
  input  wire logic                    rst_n,               // Synchronous reset, low.
  input  wire logic [ADDR_W-1:0]       avs_address,         // Byte address.
  input  wire logic                    avs_read,            // Read request.
  input  wire logic                    avs_write,           // Write request.
  input  wire logic [31:0]             avs_writedata,       // Write data.
  input  wire logic [3:0]              avs_byteenable,      // Byte lanes.
  output logic [31:0]                  avs_readdata,        // Read data.
  output logic                         avs_waitrequest,     // Stall.
  output logic [1:0]                   avs_response,        // 00 ok, 11 unmapped.
  input  wire logic                    port_is_endpoint,    // Strap: endpoint role.
  input  wire logic [2:0]              pend,                // Pending P, NP, C.
  input  wire logic                    user_ready,          // User takes a TLP.
  output logic [2:0]                   grant,               // One-hot grant P, NP, C.
  input  wire logic                    cpl_relaxed_in,      // Received RO attribute.
  output logic                         cpl_relaxed_out,     // Effective RO attribute.
  input  wire logic                    tlp_rx,              // TLP reception pulse.
  input  wire logic                    ram_rd,              // Buffer RAM read pulse.
  output logic                         inject_prefix,       // Prefix parity inject.
  output logic                         inject_parity,       // Parity inject.
  output logic                         inject_double,       // Double-bit inject.
  output logic                         inject_single,       // Single-bit inject.
  input  wire logic                    det_prefix,          // Prefix parity seen.
  input  wire logic                    det_parity,          // Parity error seen.
  input  wire logic                    det_double,          // Double-bit error seen.
  input  wire logic                    det_single,          // Single-bit error seen.
  output logic                         correct_single,      // Correct single-bit.
  output logic                         handle_uncorrectable, // Handle as uncorrectable.
  output logic                         err_report,          // Report pulse.
  output logic                         cpl_adv_infinite,    // Advertise infinite C.
  input  wire rxbuf_pkg::credit_set_type cred_initial,      // Initial advertisements.
  input  wire rxbuf_pkg::credit_set_type cred_current,      // Current available.
  input  wire rxbuf_pkg::credit_set_type cred_implemented   // Implemented amounts.
);
  // ==========================================================
  // Register storage.
  logic [31:0] ctl_q;
  logic        prio_q;
  logic        ro_ovr_q;
  rxbuf_pkg::advert_choice_type      adv_q;
  rxbuf_pkg::credit_view_choice_type view_q;
  logic [3:0]  flags_q;
  logic        ack_q;
  logic [31:0] wmask;
  logic        wr_go;
  logic        rd_go;
  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end
  logic        take;
  // A request is taken while waitrequest is high; a write lands on the edge at which
  // the master sees waitrequest low, with address and data still held.
  assign take  = (avs_read || avs_write) && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign rd_go = avs_read && !ack_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_q    <= `RESET_ZERO;
      prio_q   <= 1'b0;
      ro_ovr_q <= 1'b0;
      adv_q    <= rxbuf_pkg::ADV_BY_PORT;
      view_q   <= rxbuf_pkg::VIEW_INITIAL;
    end else if (wr_go) begin
      unique case (avs_address)
        `OFS_COMPLETION_HANDLING: begin
          if (avs_byteenable[0]) begin
            prio_q   <= avs_writedata[`BIT_PRIORITY];
            ro_ovr_q <= avs_writedata[`BIT_RELAXED_OVERRIDE];
          end
        end
        `OFS_COMPLETION_ADVERT: begin
          if (avs_byteenable[0]) begin
            adv_q <= rxbuf_pkg::advert_choice_type'(avs_writedata[1:0]);
          end
        end
        `OFS_INTEGRITY_CONTROL: begin
          ctl_q <= ((ctl_q & ~wmask) | (avs_writedata & wmask)) & `CONTROL_MASK;
        end
        `OFS_CREDIT_VIEW_SELECT: begin
          if (avs_byteenable[0]) begin
            view_q <= rxbuf_pkg::credit_view_choice_type'(avs_writedata[1:0]);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Avalon handshake: every access answered one cycle after request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q           <= take;
      avs_waitrequest <= !take;
    end
  end

  rxbuf_pkg::credit_set_type sel_set;
  always_comb begin
    unique case (view_q)
      rxbuf_pkg::VIEW_INITIAL:     sel_set = cred_initial;
      rxbuf_pkg::VIEW_CURRENT:     sel_set = cred_current;
      rxbuf_pkg::VIEW_IMPLEMENTED: sel_set = cred_implemented;
      default:                     sel_set = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= `RESET_ZERO;
      avs_response <= 2'h0;
    end else if (take) begin
      avs_readdata <= `RESET_ZERO;
      avs_response <= 2'h0;
      unique case (avs_address)
        `OFS_COMPLETION_HANDLING:
          if (rd_go) avs_readdata <= {30'h0, ro_ovr_q, prio_q};
        `OFS_COMPLETION_ADVERT:
          if (rd_go) avs_readdata <= {30'h0, adv_q};
        `OFS_INTEGRITY_CONTROL:
          if (rd_go) avs_readdata <= ctl_q;
        `OFS_INTEGRITY_FLAGS:
          if (rd_go) avs_readdata <= {28'h0, flags_q};
        `OFS_CREDIT_VIEW_SELECT:
          if (rd_go) avs_readdata <= {30'h0, view_q};
        `OFS_POSTED_CREDIT_VIEW:
          if (rd_go) avs_readdata <= sel_set.p;
        `OFS_NONPOSTED_CREDIT_VIEW:
          if (rd_go) avs_readdata <= sel_set.n;
        `OFS_COMPLETION_CREDIT_VIEW:
          if (rd_go) avs_readdata <= sel_set.c;
        default: avs_response <= 2'h3;
      endcase
    end
  end

  // ==========================================================
  // Injection triggers: a rising edge of a control bit arms one injection.
  logic [3:0] trig_now;
  logic [3:0] trig_prev_q;
  logic [3:0] armed_q;
  logic [3:0] consume;
  assign trig_now = {ctl_q[`BIT_PREFIX_TRIGGER], ctl_q[`BIT_PARITY_TRIGGER],
                     ctl_q[`BIT_DOUBLE_TRIGGER], ctl_q[`BIT_SINGLE_TRIGGER]};
  assign consume  = {tlp_rx, tlp_rx, ram_rd, ram_rd};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_prev_q <= 4'h0;
    end else begin
      trig_prev_q <= trig_now;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_arm
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          armed_q[gi] <= 1'b0;
        end else if (trig_now[gi] && !trig_prev_q[gi]) begin
          armed_q[gi] <= 1'b1;
        end else if (consume[gi]) begin
          armed_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {inject_prefix, inject_parity, inject_double, inject_single} <= 4'h0;
    end else begin
      {inject_prefix, inject_parity, inject_double, inject_single} <= armed_q & consume;
    end
  end

  // ==========================================================
  // Error detection, handling and sticky flags.
  logic       single_as_double;
  logic [3:0] report_ok;
  logic [3:0] w1c;
  logic [3:0] seen_err;
  assign single_as_double = det_single && ctl_q[`BIT_SINGLE_CORRECT_OFF];
  assign report_ok[`FLAG_PREFIX] = det_prefix && !ctl_q[`BIT_PARITY_REPORT_OFF];
  assign report_ok[`FLAG_PARITY] = det_parity && !ctl_q[`BIT_PARITY_REPORT_OFF];
  assign report_ok[`FLAG_DOUBLE] = (det_double || single_as_double)
                                   && !ctl_q[`BIT_DOUBLE_REPORT_OFF];
  assign report_ok[`FLAG_SINGLE] = det_single && !ctl_q[`BIT_SINGLE_CORRECT_OFF]
                                   && !ctl_q[`BIT_SINGLE_REPORT_OFF];
  assign w1c = (wr_go && avs_address == `OFS_INTEGRITY_FLAGS && avs_byteenable[0])
               ? avs_writedata[3:0] : 4'h0;
  // Status flags record detection; the report-off bits only silence reporting.
  assign seen_err[`FLAG_PREFIX] = det_prefix;
  assign seen_err[`FLAG_PARITY] = det_parity;
  assign seen_err[`FLAG_DOUBLE] = det_double || single_as_double;
  assign seen_err[`FLAG_SINGLE] = det_single && !ctl_q[`BIT_SINGLE_CORRECT_OFF];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~w1c) | seen_err;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      correct_single       <= 1'b0;
      handle_uncorrectable <= 1'b0;
      err_report           <= 1'b0;
    end else begin
      correct_single       <= det_single && !ctl_q[`BIT_SINGLE_CORRECT_OFF];
      handle_uncorrectable <= (det_double || single_as_double)
                              && !ctl_q[`BIT_DOUBLE_HANDLING_OFF];
      err_report           <= |report_ok;
    end
  end

  // ==========================================================
  // Completion ordering attribute and credit advertisement.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpl_relaxed_out  <= 1'b0;
      cpl_adv_infinite <= 1'b0;
    end else begin
      cpl_relaxed_out <= cpl_relaxed_in || ro_ovr_q;
      unique case (adv_q)
        rxbuf_pkg::ADV_BY_PORT:  cpl_adv_infinite <= port_is_endpoint;
        rxbuf_pkg::ADV_ACTUAL:   cpl_adv_infinite <= 1'b0;
        rxbuf_pkg::ADV_INFINITE: cpl_adv_infinite <= 1'b1;
        default:                 cpl_adv_infinite <= port_is_endpoint;
      endcase
    end
  end

  // ==========================================================
  // Arbiter: round robin, or completion priority with starvation limit.
  rxbuf_pkg::arb_state_type last_q;
  logic [3:0]               starve_q;
  logic [2:0]               pick;
  logic                     force_req;
  logic                     np_turn_q;
  assign force_req = (starve_q >= `ARB_STARVE_LIMIT) && (pend[0] || pend[1]);

  always_comb begin
    pick = 3'h0;
    if (prio_q && pend[2] && !force_req) begin
      pick = 3'b100;
    end else if (prio_q && pend[2]) begin
      // Forced turns alternate, so neither posted nor non-posted traffic can starve.
      pick = ((np_turn_q && pend[1]) || !pend[0]) ? 3'b010 : 3'b001;
    end else begin
      unique case (last_q)
        rxbuf_pkg::ARB_POSTED:
          pick = pend[1] ? 3'b010 : pend[2] ? 3'b100 : pend[0] ? 3'b001 : 3'b000;
        rxbuf_pkg::ARB_NONPOSTED:
          pick = pend[2] ? 3'b100 : pend[0] ? 3'b001 : pend[1] ? 3'b010 : 3'b000;
        default:
          pick = pend[0] ? 3'b001 : pend[1] ? 3'b010 : pend[2] ? 3'b100 : 3'b000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      grant <= 3'h0;
    end else begin
      grant <= user_ready ? pick : 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_q    <= rxbuf_pkg::ARB_COMPL;
      starve_q  <= 4'h0;
      np_turn_q <= 1'b0;
    end else if (user_ready && pick != 3'h0) begin
      last_q <= pick[0] ? rxbuf_pkg::ARB_POSTED :
                pick[1] ? rxbuf_pkg::ARB_NONPOSTED : rxbuf_pkg::ARB_COMPL;
      starve_q <= (pick[2] && (pend[0] || pend[1])) ? starve_q + 4'h1 : 4'h0;
      if (pick[0] || pick[1]) begin
        np_turn_q <= pick[0];
      end
    end
  end
endmodule : rx_buffer_control
`default_nettype wire

/* File: testbench/rx_buffer_control_asserts.sv */
// Port-level concurrent checks for the receive buffer control block.
`timescale 1ns/10ps
`default_nettype none
module rx_buffer_control_asserts (
  input wire logic        clk,                  // Clock.
  input wire logic        rst_n,                // Reset.
  input wire logic [11:0] avs_address,          // Address.
  input wire logic        avs_read,             // Read.
  input wire logic [31:0] avs_readdata,         // Read data.
  input wire logic        avs_waitrequest,      // Stall.
  input wire logic [1:0]  avs_response,         // Response.
  input wire logic [2:0]  pend,                 // Pending.
  input wire logic        user_ready,           // Ready.
  input wire logic [2:0]  grant,                // Grant.
  input wire logic        cpl_relaxed_in,       // RO in.
  input wire logic        cpl_relaxed_out,      // RO out.
  input wire logic        tlp_rx,               // TLP pulse.
  input wire logic        ram_rd,               // RAM read.
  input wire logic        inject_prefix,        // Inject.
  input wire logic        inject_parity,        // Inject.
  input wire logic        inject_double,        // Inject.
  input wire logic        inject_single,        // Inject.
  input wire logic        det_prefix,           // Detect.
  input wire logic        det_parity,           // Detect.
  input wire logic        det_double,           // Detect.
  input wire logic        det_single,           // Detect.
  input wire logic        correct_single,       // Correct.
  input wire logic        handle_uncorrectable, // Handle.
  input wire logic        err_report            // Report.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_grant_cause: assert property (grant != 3'h0 |->
    $onehot(grant) && $past(user_ready) && (grant & $past(pend)) != 3'h0)
    else $error("grant without a pending request");
  chk_lone_cpl: assert property (user_ready && pend == 3'h4 |=> grant == 3'h4)
    else $error("pending completion not granted");
  chk_relaxed_out: assert property ($past(rst_n) && $past(cpl_relaxed_in) |->
    cpl_relaxed_out) else $error("relaxed attribute lost");
  chk_inject_prefix: assert property (inject_prefix |-> $past(tlp_rx))
    else $error("prefix inject without reception");
  chk_inject_parity: assert property (inject_parity |-> $past(tlp_rx))
    else $error("parity inject without reception");
  chk_inject_double: assert property (inject_double |-> $past(ram_rd))
    else $error("double inject without ram read");
  chk_inject_single: assert property (inject_single |-> $past(ram_rd))
    else $error("single inject without ram read");
  chk_report_cause: assert property (err_report |->
    $past(det_prefix | det_parity | det_double | det_single)) else $error("stray report");
  chk_correct_cause: assert property (correct_single |->
    $past(det_single) && !handle_uncorrectable) else $error("stray correction");
  chk_handle_cause: assert property (handle_uncorrectable |->
    $past(det_double | det_single)) else $error("stray uncorrectable handling");
  chk_unmapped_read: assert property (!avs_waitrequest && avs_read &&
    !(avs_address inside {12'h0108, 12'h010c, 12'h0110, 12'h0114, 12'h0120, 12'h0124,
    12'h0128, 12'h012c}) |-> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("unmapped read answered");
  cover property (grant == 3'h4);
  cover property (inject_double);
  cover property (err_report && handle_uncorrectable);
endmodule : rx_buffer_control_asserts
`default_nettype wire

/* File: testbench/tlp_user_sink.sv */
// User logic that takes received TLPs, promptly or with random stalls.
`timescale 1ns/10ps
`default_nettype none
module tlp_user_sink (
  input wire logic  clk,        // Clock.
  input wire logic  rst_n,      // Reset.
  input wire logic  slow,       // Stall at random.
  input wire logic  [2:0] grant, // Grant seen.
  output var logic  user_ready, // Ready to take.
  output var logic  [7:0] taken // TLPs taken.
);
  logic [31:0] seed = 32'h0000_faeb;
  always @(posedge clk) begin
    if (!rst_n) begin
      user_ready <= 1'b0;
      taken <= 8'h00;
    end else begin
      user_ready <= slow ? 1'($random(seed)) : 1'b1;
      taken <= taken + 8'(grant != 3'h0);
    end
  end
endmodule : tlp_user_sink
`default_nettype wire

/* File: testbench/rx_buffer_control_tb.sv */
// Self-checking bench for the receive buffer control block.
`timescale 1ns/10ps
`default_nettype none
`include "rxbuf_defs.svh"
module rx_buffer_control_tb;
  logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0;
  logic        port_is_endpoint = 1'b0, cpl_relaxed_in = 1'b0, user_ready, cpl_relaxed_out;
  logic        avs_waitrequest, inject_prefix, inject_parity, inject_double, inject_single;
  logic        correct_single, handle_uncorrectable, err_report, cpl_adv_infinite;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat, d;
  logic [1:0]  avs_response, resp;
  logic [2:0]  pend = 3'h0, grant, g, acc;
  logic [5:0]  pls = 6'h00;
  logic [3:0]  be = 4'hf;
  rxbuf_pkg::credit_set_type cred_initial = '0, cred_current = '0, cred_implemented = '0;
  logic [11:0] ofs [8] = '{`OFS_COMPLETION_HANDLING, `OFS_COMPLETION_ADVERT,
    `OFS_INTEGRITY_CONTROL, `OFS_INTEGRITY_FLAGS, `OFS_CREDIT_VIEW_SELECT,
    `OFS_POSTED_CREDIT_VIEW, `OFS_NONPOSTED_CREDIT_VIEW, `OFS_COMPLETION_CREDIT_VIEW};
  logic [31:0] ctl [3] = '{32'h0000_0000, 32'h0004_1018, 32'h0000_0800};
  int          inj [4] = '{17, 16, 8, 0};
  int          seed = 64235, fail_count = 0, checks = 0, nc;
  rx_buffer_control dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .port_is_endpoint(port_is_endpoint), .pend(pend),
    .user_ready(user_ready), .grant(grant), .cpl_relaxed_in(cpl_relaxed_in),
    .cpl_relaxed_out(cpl_relaxed_out), .tlp_rx(pls[4]), .ram_rd(pls[5]),
    .inject_prefix(inject_prefix), .inject_parity(inject_parity),
    .inject_double(inject_double), .inject_single(inject_single), .det_prefix(pls[0]),
    .det_parity(pls[1]), .det_double(pls[2]), .det_single(pls[3]),
    .correct_single(correct_single), .handle_uncorrectable(handle_uncorrectable),
    .err_report(err_report), .cpl_adv_infinite(cpl_adv_infinite),
    .cred_initial(cred_initial), .cred_current(cred_current),
    .cred_implemented(cred_implemented));
  tlp_user_sink sink (.clk(clk), .rst_n(rst_n), .slow(slow), .grant(grant),
    .user_ready(user_ready), .taken());
  // ==========================================================
  // Checking, bus and stimulus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    rdat = avs_readdata;
    resp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 64) begin
      fail_count++;
      end_sim();
    end
  endtask : bus
  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    pls <= v;
    @(posedge clk);
    pls <= 6'h00;
    @(posedge clk);
  endtask : pulse
  task automatic grab(output logic [2:0] gv);
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (grant === 3'h0 && n < 64);
    gv = grant;
    if (n == 64) begin
      fail_count++;
      end_sim();
    end
  endtask : grab
  function automatic logic [31:0] view(input logic [1:0] s, input int k);
    rxbuf_pkg::credit_set_type t;
    t = s == 2'h0 ? cred_initial : s == 2'h1 ? cred_current : cred_implemented;
    if (s == 2'h3) return 32'h0;
    return k == 0 ? t.p : k == 1 ? t.n : t.c;
  endfunction : view
  // ==========================================================
  // Main sequence
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #3_000_000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      chk("reset value", rdat, 32'h0);
    end
    bus(1'b0, 12'h0118, 32'h0);
    chk("unmapped response", 32'(resp), 32'h3);
    d = $random(seed);
    bus(1'b1, ofs[2], d);
    bus(1'b0, ofs[2], 32'h0);
    chk("control bits", rdat, d & `CONTROL_MASK);
    bus(1'b1, ofs[0], 32'hffff_ffff);
    bus(1'b0, ofs[0], 32'h0);
    chk("handling bits", rdat, 32'h3);
    bus(1'b1, ofs[2], 32'h0);
    pulse(6'h30);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ofs[2], 32'h1 << inj[i]);
      pulse(i < 2 ? 6'h10 : 6'h20);
      chk("inject", {inject_prefix, inject_parity, inject_double, inject_single}, 4'h8 >> i);
      pulse(6'h30);
      chk("inject once", {inject_prefix, inject_parity, inject_double, inject_single}, 0);
      bus(1'b1, ofs[2], 32'h0);
    end
    $display("test injection done");
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, ofs[2], ctl[c]);
      for (int j = 0; j < 4; j++) begin
        pulse(6'h01 << j);
        chk("error outputs", {err_report, correct_single, handle_uncorrectable}, {c != 1, j == 3 && c != 1, (j == 2 && c != 2) || (j == 3 && c == 1)});
        repeat (3) @(posedge clk);
        bus(1'b0, ofs[3], 32'h0);
        d = (c == 1 && j == 3) ? 32'h2 : 32'h8 >> j;
        chk("flags", rdat, d);
        be <= 4'he;
        bus(1'b1, ofs[3], 32'hf);
        be <= 4'hf;
        bus(1'b0, ofs[3], 32'h0);
        chk("flags kept", rdat, d);
        bus(1'b1, ofs[3], 32'hf);
        bus(1'b0, ofs[3], 32'h0);
        chk("flags cleared", rdat, 32'h0);
      end
    end
    bus(1'b1, ofs[2], 32'h0);
    $display("test errors done");
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, ofs[0], 32'(r & 2));
      cpl_relaxed_in <= r[0];
      repeat (2) @(posedge clk);
      chk("relaxed out", cpl_relaxed_out, r[0] | r[1]);
    end
    for (int e = 0; e < 2; e++) begin
      port_is_endpoint <= e[0];
      for (int a = 0; a < 4; a++) begin
        bus(1'b1, ofs[1], 32'(a));
        repeat (2) @(posedge clk);
        chk("advert infinite", cpl_adv_infinite,
          a == 2 || ((a == 0 || a == 3) && e == 1));
      end
    end
    $display("test completion handling done");
    @(posedge clk);
    cred_initial <= {$random(seed), $random(seed), $random(seed)};
    cred_current <= {$random(seed), $random(seed), $random(seed)};
    cred_implemented <= {$random(seed), $random(seed), $random(seed)};
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, ofs[4], 32'(s));
      for (int k = 0; k < 3; k++) begin
        bus(1'b0, ofs[5 + k], 32'h0);
        chk("credit view", rdat, view(2'(s), k));
      end
    end
    $display("test credit views done");
    bus(1'b1, ofs[0], 32'h0);
    slow <= 1'b1;
    pend <= 3'h7;
    acc = 3'h0;
    repeat (3) begin
      grab(g);
      acc = acc | g;
    end
    chk("round robin", acc, 3'h7);
    pend <= 3'h0;
    bus(1'b1, ofs[0], 32'h1);
    slow <= 1'b0;
    pend <= 3'h4;
    grab(g);
    chk("lone completion", g, 3'h4);
    pend <= 3'h7;
    nc = 0;
    acc = 3'h0;
    for (int i = 0; i < 36; i++) begin
      grab(g);
      acc = acc | g;
      nc += int'(g != 3'h4);
    end
    chk("starvation relief", 32'(nc inside {[3:4]}), 32'h1);
    chk("both requests served", 32'(acc), 32'h7);
    pend <= 3'h0;
    $display("test arbitration done");
    end_sim();
  end
endmodule : rx_buffer_control_tb
bind rx_buffer_control rx_buffer_control_asserts chk_i (.*);
`default_nettype wire
